// [logic/ber_pkg.sv]
// Package with register map, field layout and constants of the error-rate tester.
package ber_pkg;
    localparam logic [15:0] ADDR_CTL_TWO = 16'h1106;
    localparam logic [15:0] ADDR_BIT_CNT_B0 = 16'h1107;
    localparam logic [15:0] ADDR_BIT_CNT_B1 = 16'h1108;
    localparam logic [15:0] ADDR_BIT_CNT_B2 = 16'h1109;
    localparam logic [15:0] ADDR_BIT_CNT_B3 = 16'h110A;
    localparam logic [15:0] ADDR_ERR_CNT_B0 = 16'h110B;
    localparam logic [15:0] ADDR_ERR_CNT_B1 = 16'h110C;
    localparam logic [15:0] ADDR_ERR_CNT_B2 = 16'h110D;
    localparam logic [15:0] ADDR_STATUS = 16'h110E;
    localparam logic [15:0] ADDR_MASK = 16'h110F;

    localparam logic [7:0] CTL_TWO_RESET = 8'h00;
    localparam logic [6:0] MASK_RESET = 7'h00;
    localparam logic [6:0] STATUS_RESET = 7'h00;

    // Field positions in the control two register.
    localparam int RATE_MSB = 7;
    localparam int RATE_LSB = 5;
    localparam int SINGLE_ERR_BIT = 4;
    localparam int LEN_MSB = 3;
    localparam int LEN_LSB = 0;

    // Status and mask bit positions.
    localparam int ST_IN_SYNC = 0;
    localparam int ST_SYNC_LOST = 1;
    localparam int ST_ALL_ZEROS = 2;
    localparam int ST_ALL_ONES = 3;
    localparam int ST_ERR_OVF = 4;
    localparam int ST_BIT_OVF = 5;
    localparam int ST_ERR_DET = 6;

    localparam logic [5:0] REPEAT_LEN_BASE = 6'h11;
    localparam logic [5:0] RUN_LIMIT = 6'h20;
    localparam logic [5:0] SYNC_MATCH_LAST = 6'h1F;

    localparam logic [23:0] RATE_1E1 = 24'h00000A;
    localparam logic [23:0] RATE_1E2 = 24'h000064;
    localparam logic [23:0] RATE_1E3 = 24'h0003E8;
    localparam logic [23:0] RATE_1E4 = 24'h002710;
    localparam logic [23:0] RATE_1E5 = 24'h0186A0;
    localparam logic [23:0] RATE_1E6 = 24'h0F4240;
    localparam logic [23:0] RATE_1E7 = 24'h989680;

    typedef enum logic {BER_SEARCH, BER_LOCKED} ber_sync_t;

    // Number of generated bits between two injected errors; zero means off.
    function automatic logic [23:0] ber_rate_period(input logic [2:0] code);
        case (code)
            3'h1: ber_rate_period = RATE_1E1;
            3'h2: ber_rate_period = RATE_1E2;
            3'h3: ber_rate_period = RATE_1E3;
            3'h4: ber_rate_period = RATE_1E4;
            3'h5: ber_rate_period = RATE_1E5;
            3'h6: ber_rate_period = RATE_1E6;
            3'h7: ber_rate_period = RATE_1E7;
            default: ber_rate_period = 24'h000000;
        endcase
    endfunction
endpackage

// [logic/ber_tester.sv]
// Error injection, counting, status and mask logic of the error-rate tester.
`timescale 1ns/1ps
`default_nettype none

module ber_tester
    import ber_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic [15:0] ADDR,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [7:0] WDATA,
    output logic [7:0] RDATA,
    input wire logic PRBS_MODE,
    input wire logic COUNT_LATCH_PULSE,
    input wire logic FORCE_SEARCH_PULSE,
    input wire logic TX_VALID,
    input wire logic TX_BIT,
    output logic TX_OUT_VALID,
    output logic TX_OUT_BIT,
    input wire logic RX_VALID,
    input wire logic RX_BIT,
    input wire logic RX_EXPECTED,
    output logic [5:0] REPEAT_LEN,
    output logic SEARCHING,
    output logic IRQ
);
    typedef struct packed {
        logic [7:0] ctl2;
        logic [6:0] mask;
        logic [6:0] status;
        logic [31:0] bit_cnt;
        logic [23:0] err_cnt;
        logic [31:0] bit_hold;
        logic [23:0] err_hold;
        logic [23:0] rate_cnt;
        logic sbe_prev;
        logic sbe_pend;
        logic latch_prev;
        logic rsync_prev;
        ber_sync_t sync;
        logic searching;
        logic [5:0] match_cnt;
        logic [5:0] run_cnt;
        logic run_val;
        logic ones_cond;
        logic zeros_cond;
        logic [7:0] rdata;
        logic tx_vld;
        logic tx_bit;
        logic [5:0] rep_len;
        logic irq;
    } ber_state_t;

    ber_state_t s_r;
    ber_state_t s_nxt;

    logic [23:0] period;
    logic [6:0] set_ev;
    logic [6:0] clr_ev;
    logic inject;
    logic err_hit;
    logic bit_inc;
    logic latch_edge;
    logic search_edge;
    logic ones_new;
    logic zeros_new;
    logic [5:0] run_new;

    always_comb begin
        s_nxt = s_r;
        set_ev = 7'h00;
        clr_ev = 7'h00;
        inject = 1'b0;
        err_hit = 1'b0;
        bit_inc = 1'b0;
        run_new = s_r.run_cnt;
        ones_new = s_r.ones_cond;
        zeros_new = s_r.zeros_cond;
        period = ber_rate_period(s_r.ctl2[RATE_MSB:RATE_LSB]);
        latch_edge = COUNT_LATCH_PULSE & ~s_r.latch_prev;
        search_edge = FORCE_SEARCH_PULSE & ~s_r.rsync_prev;

        // Register writes.
        if (WR_EN) begin
            case (ADDR)
                ADDR_CTL_TWO: s_nxt.ctl2 = WDATA;
                ADDR_MASK: s_nxt.mask = WDATA[6:0];
                default: ;
            endcase
        end

        // Pattern length goes to the generator, dropped for PRBS.
        if (PRBS_MODE) begin
            s_nxt.rep_len = 6'h00;
        end else begin
            s_nxt.rep_len = {2'h0, s_r.ctl2[LEN_MSB:LEN_LSB]}
                + REPEAT_LEN_BASE;
        end

        // Single error is armed on the edge and spent on the next bit.
        s_nxt.sbe_prev = s_r.ctl2[SINGLE_ERR_BIT];
        if (s_r.ctl2[SINGLE_ERR_BIT] & ~s_r.sbe_prev) begin
            s_nxt.sbe_pend = 1'b1;
        end

        // Transmit path with error injection.
        s_nxt.tx_vld = TX_VALID;
        if (TX_VALID) begin
            if (period != 24'h000000) begin
                if (s_r.rate_cnt >= period - 24'h000001) begin
                    s_nxt.rate_cnt = 24'h000000;
                    inject = 1'b1;
                end else begin
                    s_nxt.rate_cnt = s_r.rate_cnt + 24'h000001;
                end
            end else begin
                s_nxt.rate_cnt = 24'h000000;
            end
            if (s_r.sbe_pend) begin
                inject = 1'b1;
                s_nxt.sbe_pend = 1'b0;
            end
            s_nxt.tx_bit = TX_BIT ^ inject;
        end

        // Receive checker: search, lock and forced force_search_pulse.
        s_nxt.rsync_prev = FORCE_SEARCH_PULSE;
        if (search_edge) begin
            s_nxt.sync = BER_SEARCH;
            s_nxt.match_cnt = 6'h00;
        end else if (RX_VALID) begin
            if (s_r.sync == BER_SEARCH) begin
                if (RX_BIT != RX_EXPECTED) begin
                    s_nxt.match_cnt = 6'h00;
                end else if (s_r.match_cnt == SYNC_MATCH_LAST) begin
                    s_nxt.sync = BER_LOCKED;
                    s_nxt.match_cnt = 6'h00;
                end else begin
                    s_nxt.match_cnt = s_r.match_cnt + 6'h01;
                end
            end else begin
                bit_inc = 1'b1;
                err_hit = RX_BIT != RX_EXPECTED;
            end
        end

        // Condition flags fire on every change of the sync state.
        if (s_nxt.sync != s_r.sync) begin
            set_ev[ST_SYNC_LOST] = 1'b1;
            set_ev[ST_IN_SYNC] = 1'b1;
        end
        // A forced restart while already searching is still a new search.
        if (search_edge) begin
            set_ev[ST_SYNC_LOST] = 1'b1;
        end
        s_nxt.searching = s_nxt.sync == BER_SEARCH;

        // Runs of equal received bits for all-ones and all-zeros.
        if (RX_VALID) begin
            if (RX_BIT != s_r.run_val) begin
                run_new = 6'h01;
            end else if (s_r.run_cnt != RUN_LIMIT) begin
                run_new = s_r.run_cnt + 6'h01;
            end
            s_nxt.run_val = RX_BIT;
            s_nxt.run_cnt = run_new;
            ones_new = RX_BIT & (run_new == RUN_LIMIT);
            zeros_new = ~RX_BIT & (run_new == RUN_LIMIT);
        end
        s_nxt.ones_cond = ones_new;
        s_nxt.zeros_cond = zeros_new;
        set_ev[ST_ALL_ONES] = ones_new != s_r.ones_cond;
        set_ev[ST_ALL_ZEROS] = zeros_new != s_r.zeros_cond;

        // Counters, overflow and latch into the readable copies.
        set_ev[ST_ERR_DET] = err_hit;
        // A latch clears the counters instead of wrapping them.
        set_ev[ST_BIT_OVF] = bit_inc & ~latch_edge & (&s_r.bit_cnt);
        set_ev[ST_ERR_OVF] = err_hit & ~latch_edge & (&s_r.err_cnt);
        s_nxt.latch_prev = COUNT_LATCH_PULSE;
        if (latch_edge) begin
            s_nxt.bit_hold = s_r.bit_cnt;
            s_nxt.err_hold = s_r.err_cnt;
            s_nxt.bit_cnt = 32'h00000000;
            s_nxt.err_cnt = 24'h000000;
        end else begin
            if (bit_inc) begin
                s_nxt.bit_cnt = s_r.bit_cnt + 32'h00000001;
            end
            if (err_hit) begin
                s_nxt.err_cnt = s_r.err_cnt + 24'h000001;
            end
        end

        // Register reads; reading status clears it, but new events win.
        if (RD_EN) begin
            case (ADDR)
                ADDR_CTL_TWO: s_nxt.rdata = s_r.ctl2;
                ADDR_BIT_CNT_B0: s_nxt.rdata = s_r.bit_hold[7:0];
                ADDR_BIT_CNT_B1: s_nxt.rdata = s_r.bit_hold[15:8];
                ADDR_BIT_CNT_B2: s_nxt.rdata = s_r.bit_hold[23:16];
                ADDR_BIT_CNT_B3: s_nxt.rdata = s_r.bit_hold[31:24];
                ADDR_ERR_CNT_B0: s_nxt.rdata = s_r.err_hold[7:0];
                ADDR_ERR_CNT_B1: s_nxt.rdata = s_r.err_hold[15:8];
                ADDR_ERR_CNT_B2: s_nxt.rdata = s_r.err_hold[23:16];
                ADDR_STATUS: begin
                    s_nxt.rdata = {1'b0, s_r.status};
                    clr_ev = 7'h7F;
                end
                ADDR_MASK: s_nxt.rdata = {1'b0, s_r.mask};
                default: s_nxt.rdata = 8'h00;
            endcase
        end
        s_nxt.status = (s_r.status & ~clr_ev) | set_ev;
        s_nxt.irq = |(s_nxt.status & s_r.mask);
    end

    // Clock enable low freezes every flip-flop of the block.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_r <= '0;
            s_r.ctl2 <= CTL_TWO_RESET;
            s_r.mask <= MASK_RESET;
            s_r.status <= STATUS_RESET;
            s_r.sync <= BER_SEARCH;
            s_r.searching <= 1'b1;
        end else if (CE) begin
            s_r <= s_nxt;
        end
    end

    assign RDATA = s_r.rdata;
    assign TX_OUT_VALID = s_r.tx_vld;
    assign TX_OUT_BIT = s_r.tx_bit;
    assign REPEAT_LEN = s_r.rep_len;
    assign SEARCHING = s_r.searching;
    assign IRQ = s_r.irq;
endmodule

`default_nettype wire

// [dv/ber_tester_sva.sv]
// Port-level assertions for the error-rate tester.
`timescale 1ns/1ps
`default_nettype none
module ber_tester_chk
    import ber_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic [15:0] ADDR,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [7:0] WDATA,
    input wire logic [7:0] RDATA,
    input wire logic PRBS_MODE,
    input wire logic FORCE_SEARCH_PULSE,
    input wire logic TX_VALID,
    input wire logic TX_OUT_VALID,
    input wire logic TX_OUT_BIT,
    input wire logic RX_VALID,
    input wire logic RX_BIT,
    input wire logic RX_EXPECTED,
    input wire logic [5:0] REPEAT_LEN,
    input wire logic SEARCHING,
    input wire logic IRQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_force;
        CE && $rose(FORCE_SEARCH_PULSE);
    endsequence
    sequence s_mask_off;
        CE && WR_EN && ADDR == ADDR_MASK && WDATA == 8'h00;
    endsequence
    chk_tx_echo: assert property (CE && TX_VALID |=> TX_OUT_VALID)
        else $error("tx strobe not echoed");
    chk_tx_idle_hold: assert property (CE && !TX_VALID
        |=> !TX_OUT_VALID && $stable(TX_OUT_BIT))
        else $error("tx output moved without strobe");
    chk_len_prbs: assert property (CE && PRBS_MODE |=> REPEAT_LEN == 6'h00)
        else $error("length not ignored in prbs mode");
    chk_len_span: assert property (CE && !PRBS_MODE
        |=> REPEAT_LEN inside {[REPEAT_LEN_BASE:RUN_LIMIT]})
        else $error("pattern length out of range");
    chk_rdata_hold: assert property ((!RD_EN) [*2] |=> $stable(RDATA))
        else $error("read data changed without read");
    chk_force_search: assert property (s_force |-> ##[1:2] SEARCHING)
        else $error("force_search_pulse did not restart search");
    chk_lock_cause: assert property ($fell(SEARCHING)
        |-> $past(RX_VALID) && $past(RX_BIT) == $past(RX_EXPECTED))
        else $error("lock without matching bit");
    chk_mask_gate: assert property (s_mask_off |-> ##2 !IRQ)
        else $error("interrupt passed a zero mask");
endmodule
`default_nettype wire

// [dv/ber_far.sv]
// Behavioural framer serial paths facing the tester.
`timescale 1ns/1ps
`default_nettype none
module ber_far (
    input wire logic CLK,
    output logic TX_VALID,
    output logic TX_BIT,
    output logic RX_VALID,
    output logic RX_BIT,
    output logic RX_EXPECTED
);
    initial {TX_VALID, TX_BIT, RX_VALID, RX_BIT, RX_EXPECTED} = 5'h00;
    // Released data lines show the inverse so a stale bit never passes.
    task automatic tx(input logic b);
        @(negedge CLK) {TX_VALID, TX_BIT} = {1'b1, b};
        @(negedge CLK) {TX_VALID, TX_BIT} = {1'b0, ~b};
    endtask
    task automatic rx(input logic b, input logic e);
        @(negedge CLK) {RX_VALID, RX_BIT, RX_EXPECTED} = {1'b1, b, e};
        @(negedge CLK) {RX_VALID, RX_BIT, RX_EXPECTED} = {1'b0, ~b, ~e};
    endtask
endmodule
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench of the error-rate tester.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
    $display("mismatch %0t got %h exp %h", $time, a, b); end end
module testbench;
    import ber_pkg::*;
    logic CLK = 0, RST_N = 0, CE = 1, WR_EN = 0, RD_EN = 0;
    logic PRBS_MODE = 0, COUNT_LATCH_PULSE = 0, FORCE_SEARCH_PULSE = 0;
    logic [15:0] ADDR = 16'h0000;
    logic [7:0] WDATA = 8'h00;
    logic [7:0] RDATA;
    logic [5:0] REPEAT_LEN;
    logic TX_VALID, TX_BIT, TX_OUT_VALID, TX_OUT_BIT, RX_VALID, RX_BIT;
    logic RX_EXPECTED, SEARCHING, IRQ;
    int errors = 0, checked = 0;
    ber_tester i_dut (.*);
    ber_far i_far (.*);
    always #50 CLK = ~CLK;
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge CLK) {ADDR, WDATA, WR_EN} = {a, d, 1'b1};
        @(negedge CLK) WR_EN = 0;
    endtask
    // RDATA holds until the next read, so one spare cycle costs nothing.
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(negedge CLK) {ADDR, RD_EN} = {a, 1'b1};
        @(negedge CLK) RD_EN = 0;
        @(negedge CLK) `CHK(RDATA, e)
    endtask
    task automatic pulse(ref logic s);
        @(negedge CLK) s = 1;
        @(negedge CLK) s = 0;
        @(negedge CLK);
    endtask
    task automatic t_reset;
        @(negedge CLK) `CHK(REPEAT_LEN, 6'h11)
        for (int a = 16'h1106; a < 16'h1110; a++) rd(a[15:0], 8'h00);
        rd(16'h1200, 8'h00);
    endtask
    task automatic t_length;
        wr(ADDR_CTL_TWO, 8'h0F);
        rd(ADDR_CTL_TWO, 8'h0F);
        `CHK(REPEAT_LEN, 6'h20)
        // With the clock enable low the write must not land.
        CE = 0;
        wr(ADDR_CTL_TWO, 8'h01);
        CE = 1;
        rd(ADDR_CTL_TWO, 8'h0F);
        // An 18-bit length carries a 6-bit pattern three times.
        wr(ADDR_CTL_TWO, 8'h01);
        @(negedge CLK) `CHK(REPEAT_LEN, 6'h12)
        @(negedge CLK) PRBS_MODE = 1;
        @(negedge CLK) `CHK(REPEAT_LEN, 6'h00)
        PRBS_MODE = 0;
        wr(ADDR_MASK, 8'hFF);
        rd(ADDR_MASK, 8'h7F);
    endtask
    task automatic t_sync;
        wr(ADDR_MASK, 8'h03);
        for (int k = 0; k < 31; k++) i_far.rx(k[0], k[0]);
        i_far.rx(1'b1, 1'b0);
        `CHK(SEARCHING, 1'b1)
        for (int k = 0; k < 32; k++) i_far.rx(k[0], k[0]);
        @(negedge CLK) `CHK(SEARCHING, 1'b0)
        @(negedge CLK) `CHK(IRQ, 1'b1)
        rd(ADDR_STATUS, 8'h03);
        rd(ADDR_STATUS, 8'h00);
    endtask
    task automatic t_count;
        for (int k = 0; k < 5; k++) i_far.rx(k[0], k[0] ^ (k < 3));
        pulse(COUNT_LATCH_PULSE);
        `CHK(IRQ, 1'b0)
        rd(ADDR_BIT_CNT_B0, 8'h05);
        rd(ADDR_BIT_CNT_B3, 8'h00);
        rd(ADDR_ERR_CNT_B0, 8'h03);
        rd(ADDR_ERR_CNT_B2, 8'h00);
        rd(ADDR_STATUS, 8'h40);
        pulse(COUNT_LATCH_PULSE);
        rd(ADDR_BIT_CNT_B0, 8'h00);
    endtask
    task automatic t_runs;
        wr(ADDR_MASK, 8'h00);
        for (int k = 0; k < 32; k++) i_far.rx(1'b1, 1'b1);
        rd(ADDR_STATUS, 8'h08);
        i_far.rx(1'b0, 1'b0);
        rd(ADDR_STATUS, 8'h08);
        for (int k = 0; k < 31; k++) i_far.rx(1'b0, 1'b0);
        rd(ADDR_STATUS, 8'h04);
        pulse(FORCE_SEARCH_PULSE);
        `CHK(SEARCHING, 1'b1)
        rd(ADDR_STATUS, 8'h03);
        pulse(FORCE_SEARCH_PULSE);
        rd(ADDR_STATUS, 8'h02);
        i_far.rx(1'b1, 1'b0);
        pulse(COUNT_LATCH_PULSE);
        rd(ADDR_ERR_CNT_B0, 8'h00);
        rd(ADDR_BIT_CNT_B0, 8'h40);
    endtask
    task automatic t_midreset;
        @(negedge CLK) RST_N = 0;
        repeat (2) @(negedge CLK);
        `CHK(REPEAT_LEN, 6'h00)
        RST_N = 1;
        @(negedge CLK) `CHK(REPEAT_LEN, 6'h11)
        rd(ADDR_CTL_TWO, 8'h00);
    endtask
    task automatic t_tx;
        logic [19:0] got;
        wr(ADDR_CTL_TWO, 8'h10);
        // The edge arms one cycle after the write lands.
        @(negedge CLK);
        i_far.tx(1'b0);
        `CHK(TX_OUT_BIT, 1'b1)
        i_far.tx(1'b0);
        `CHK(TX_OUT_BIT, 1'b0)
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_CTL_TWO, {c[2:0], 5'h00});
            for (int k = 0; k < 20; k++) begin
                i_far.tx(1'b0);
                got[k] = TX_OUT_BIT;
            end
            `CHK(got, c == 1 ? 20'h80200 : 20'h00000)
        end
    endtask
    task automatic give_verdict;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge CLK);
        RST_N = 1;
        t_reset;
        t_length;
        t_sync;
        t_count;
        t_runs;
        t_midreset;
        t_tx;
        give_verdict;
    end
    initial begin
        repeat (20000) @(posedge CLK);
        errors++;
        give_verdict;
    end
endmodule
bind ber_tester ber_tester_chk i_chk (.*);
`default_nettype wire
